// *** spwpc_pkg.sv ***
// shared constants for the serial link port configuration block
// Operation
// RULE1: transmit and receive sampling use link clock
// RULE2: far end keeps rate within link clock
// RULE3: link clock kept within eight times system
// RULE4: every port number carries the RMAP target
// RULE5: RMAP control bits honoured on each port
// RULE6: start-up timing from divisor start field
// RULE7: write sync error status bit reads zero
// RULE8: control bit 22 loops transmit into receive
// RULE9: software keeps loopback cleared in service
// RULE10: unknown destination reports invalid address code
// RULE11: loopback bit cleared after reset
package spwpc_pkg;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          NUM_PORTS     = 4;
	localparam int          DIV_W         = 8;
	// register offsets
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_MASK      = 8'h08;
	localparam logic [7:0]  OFS_CLKDIV    = 8'h0c;
	localparam logic [7:0]  OFS_NODEADDR  = 8'h10;
	localparam logic [7:0]  OFS_TXDATA    = 8'h14;
	localparam logic [7:0]  OFS_RXDATA    = 8'h18;
	localparam logic [7:0]  OFS_RMAPERR   = 8'h1c;
	// control fields
	localparam int          CTRL_LINK_EN  = 0;
	localparam int          CTRL_RMAP_EN  = 1;
	localparam int          CTRL_LOOP     = 22;
	// status fields
	localparam int          ST_RX_EV      = 0;
	localparam int          ST_RMAP_EV    = 1;
	localparam int          ST_TX_EV      = 2;
	localparam int          ST_WSYNC      = 6;
	localparam int          ST_LINK_RUN   = 8;
	localparam int          ST_TX_BUSY    = 9;
	localparam int          EV_W          = 3;
	// clock divisor fields
	localparam int          CDIV_RUN_LSB  = 0;
	localparam int          CDIV_START_LSB = 8;
	// reset values
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
	localparam logic [7:0]  DIV_RUN_RST   = 8'h01;
	localparam logic [7:0]  DIV_START_RST = 8'h09;
	localparam logic [7:0]  NODEADDR_RST  = 8'hfe;
	// timing counts, in link clock ticks
	localparam logic [7:0]  START_TICKS   = 8'h10;
	// packet framing and error codes
	localparam logic [7:0]  PKT_END       = 8'hff;
	localparam logic [7:0]  ERR_NONE      = 8'h00;
	localparam logic [7:0]  ERR_INV_DEST  = 8'h0c;

	typedef enum logic [2:0] {
		LNK_OFF   = 3'b001,
		LNK_START = 3'b010,
		LNK_RUN   = 3'b100
	} spwpc_link_e;
endpackage : spwpc_pkg

// *** spwpc_ds_rx.sv ***
// data-strobe bit recovery and byte assembly on link clock ticks
`timescale 1ns/100ps
module spwpc_ds_rx (
	input  wire logic       ref_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       enable_i,
	input  wire logic       sample_i,
	input  wire logic       d_i,
	input  wire logic       s_i,
	output logic            byte_valid_o,
	output logic [7:0]      byte_o
);
	logic       xr_q;
	logic [7:0] sh_q;
	logic [2:0] cnt_q;
	logic       xr;

	assign xr = d_i ^ s_i;

	// inputs are only looked at on the link tick, which bounds the far-end rate [RULE1]
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || !enable_i) begin
			xr_q         <= 1'b0;
			sh_q         <= 8'h00;
			cnt_q        <= 3'h0;
			byte_valid_o <= 1'b0;
			byte_o       <= 8'h00;
		end else begin
			byte_valid_o <= 1'b0;
			if (sample_i && (xr != xr_q)) begin
				xr_q  <= xr;
				sh_q  <= {d_i, sh_q[7:1]};
				cnt_q <= cnt_q + 3'h1;
				if (cnt_q == 3'h7) begin
					byte_valid_o <= 1'b1;
					byte_o       <= {d_i, sh_q[7:1]};
				end
			end
		end
	end
endmodule : spwpc_ds_rx

// *** spwpc_port.sv ***
// one link port: registers, link clock divider, start-up, ds transmit, receive and RMAP check
`timescale 1ns/100ps
module spwpc_port #(
	parameter int PORT_ID = 0
) (
	input  wire logic                        ref_clk_i,
	input  wire logic                        nrst_i,
	input  wire logic [spwpc_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [spwpc_pkg::DATA_W-1:0] wr_data_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	output logic      [spwpc_pkg::DATA_W-1:0] rd_data_o,
	output logic                             irq_o,
	input  wire logic                        rx_d_i,
	input  wire logic                        rx_s_i,
	output logic                             tx_d_o,
	output logic                             tx_s_o,
	output logic                             link_bit_clk_o,
	output logic                             link_run_o
);
	import spwpc_pkg::*;

	// the RMAP target exists on every port number below NUM_PORTS; an out-of-range one is an elaboration error [RULE4]
	if (PORT_ID < 0 || PORT_ID >= NUM_PORTS) begin : g_bad_port
		$error("port number out of range");
	end

	logic [31:0]      ctrl_q;
	logic [EV_W-1:0]  evt_q;
	logic [EV_W-1:0]  mask_q;
	logic [DIV_W-1:0] div_run_q;
	logic [DIV_W-1:0] div_start_q;
	logic [7:0]       node_q;
	logic [7:0]       rxdata_q;
	logic [7:0]       rmap_err_q;
	spwpc_link_e      lnk_q;
	logic [DIV_W-1:0] dcnt_q;
	logic [7:0]       scnt_q;
	logic             bit_tick;
	logic [7:0]       tx_sh_q;
	logic [3:0]       tx_cnt_q;
	logic             tx_busy_q;
	logic [1:0]       d_sync_q;
	logic [1:0]       s_sync_q;
	logic             rx_d_sel;
	logic             rx_s_sel;
	logic             rx_valid;
	logic [7:0]       rx_byte;
	logic             expect_dest_q;
	logic             dest_bad;
	logic             dest_chk;
	logic [EV_W-1:0]  ev_set;
	logic [DIV_W-1:0] div_now;
	logic             wr_ctrl;
	logic             wr_tx;

	assign wr_ctrl = wr_i && (addr_i == OFS_CTRL);
	assign wr_tx   = wr_i && (addr_i == OFS_TXDATA);

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			ctrl_q <= CTRL_RST; // [RULE11]
		end else if (wr_ctrl) begin
			ctrl_q <= wr_data_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			mask_q      <= '0;
			div_run_q   <= DIV_RUN_RST;
			div_start_q <= DIV_START_RST;
			node_q      <= NODEADDR_RST;
		end else if (wr_i) begin
			if (addr_i == OFS_MASK) begin
				mask_q <= wr_data_i[EV_W-1:0];
			end
			if (addr_i == OFS_CLKDIV) begin
				div_run_q   <= wr_data_i[CDIV_RUN_LSB +: DIV_W];
				div_start_q <= wr_data_i[CDIV_START_LSB +: DIV_W];
			end
			if (addr_i == OFS_NODEADDR) begin
				node_q <= wr_data_i[7:0];
			end
		end
	end

	// link clock divider; the start value governs until the link runs [RULE6]
	assign div_now  = (lnk_q == LNK_RUN) ? div_run_q : div_start_q;
	assign bit_tick = (lnk_q != LNK_OFF) && (dcnt_q == '0);

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || lnk_q == LNK_OFF) begin
			dcnt_q         <= '0;
			link_bit_clk_o <= 1'b0;
		end else if (dcnt_q == '0) begin
			dcnt_q         <= div_now;
			link_bit_clk_o <= ~link_bit_clk_o; // [RULE1]
		end else begin
			dcnt_q <= dcnt_q - 1'b1;
		end
	end

	// no timer register: start-up waits a fixed tick count at the start rate [RULE6]
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			lnk_q      <= LNK_OFF;
			scnt_q     <= 8'h00;
			link_run_o <= 1'b0;
		end else begin
			case (lnk_q)
				LNK_OFF: begin
					scnt_q <= 8'h00;
					if (ctrl_q[CTRL_LINK_EN]) begin
						lnk_q <= LNK_START;
					end
				end
				LNK_START: begin
					if (!ctrl_q[CTRL_LINK_EN]) begin
						lnk_q <= LNK_OFF;
					end else if (bit_tick) begin
						scnt_q <= scnt_q + 8'h01;
						if (scnt_q == START_TICKS - 8'h01) begin
							lnk_q      <= LNK_RUN; // [RULE6]
							link_run_o <= 1'b1;
						end
					end
				end
				LNK_RUN: begin
					if (!ctrl_q[CTRL_LINK_EN]) begin
						lnk_q      <= LNK_OFF;
						link_run_o <= 1'b0;
					end
				end
				default: begin
					lnk_q      <= LNK_OFF;
					link_run_o <= 1'b0;
				end
			endcase
		end
	end

	// ds transmit: one bit per link tick; data or strobe toggles, never both [RULE1]
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			tx_sh_q   <= 8'h00;
			tx_cnt_q  <= 4'h0;
			tx_busy_q <= 1'b0;
			tx_d_o    <= 1'b0;
			tx_s_o    <= 1'b0;
		end else if (wr_tx && !tx_busy_q && lnk_q == LNK_RUN) begin
			tx_sh_q   <= wr_data_i[7:0];
			tx_cnt_q  <= 4'h8;
			tx_busy_q <= 1'b1;
		end else if (lnk_q == LNK_OFF) begin
			// ticks stop with the link, so a cut byte is dropped rather than left hanging
			tx_busy_q <= 1'b0;
			tx_cnt_q  <= 4'h0;
		end else if (tx_busy_q && bit_tick) begin
			if (tx_sh_q[0] != tx_d_o) begin
				tx_d_o <= tx_sh_q[0];
			end else begin
				tx_s_o <= ~tx_s_o;
			end
			tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
			tx_cnt_q <= tx_cnt_q - 4'h1;
			if (tx_cnt_q == 4'h1) begin
				tx_busy_q <= 1'b0;
			end
		end
	end

	// pins are asynchronous: two flops before anything reads them
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			d_sync_q <= 2'b00;
			s_sync_q <= 2'b00;
		end else begin
			d_sync_q <= {d_sync_q[0], rx_d_i};
			s_sync_q <= {s_sync_q[0], rx_s_i};
		end
	end

	// loopback takes the transmit flops, so the external pins are ignored meanwhile [RULE8]
	assign rx_d_sel = ctrl_q[CTRL_LOOP] ? tx_d_o : d_sync_q[1];
	assign rx_s_sel = ctrl_q[CTRL_LOOP] ? tx_s_o : s_sync_q[1];

	spwpc_ds_rx spwpc_ds_rx_inst (
		.ref_clk_i    (ref_clk_i),
		.nrst_i       (nrst_i),
		.enable_i     (lnk_q == LNK_RUN),
		.sample_i     (bit_tick),
		.d_i          (rx_d_sel),
		.s_i          (rx_s_sel),
		.byte_valid_o (rx_valid),
		.byte_o       (rx_byte)
	);

	// first byte of a packet is its destination; checked only when RMAP is enabled [RULE5]
	assign dest_chk = rx_valid && expect_dest_q && ctrl_q[CTRL_RMAP_EN];
	assign dest_bad = dest_chk && (rx_byte != node_q);

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || lnk_q != LNK_RUN) begin
			expect_dest_q <= 1'b1;
		end else if (rx_valid) begin
			expect_dest_q <= (rx_byte == PKT_END);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			rmap_err_q <= ERR_NONE;
			rxdata_q   <= 8'h00;
		end else begin
			if (dest_chk) begin
				rmap_err_q <= dest_bad ? ERR_INV_DEST : ERR_NONE; // [RULE10]
			end
			if (rx_valid) begin
				rxdata_q <= rx_byte;
			end
		end
	end

	// sticky events; a new event beats a write-one clear in the same cycle
	always_comb begin
		ev_set             = '0;
		ev_set[ST_RX_EV]   = rx_valid;
		ev_set[ST_RMAP_EV] = dest_bad; // [RULE10]
		ev_set[ST_TX_EV]   = tx_busy_q && bit_tick && (tx_cnt_q == 4'h1);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			evt_q <= '0;
		end else if (wr_i && addr_i == OFS_STATUS) begin
			evt_q <= (evt_q & ~wr_data_i[EV_W-1:0]) | ev_set;
		end else begin
			evt_q <= evt_q | ev_set;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(evt_q & mask_q);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			rd_data_o <= '0;
		end else if (rd_i) begin
			rd_data_o <= '0;
			case (addr_i)
				OFS_CTRL:     rd_data_o <= ctrl_q;
				OFS_STATUS: begin
					rd_data_o[EV_W-1:0]   <= evt_q;
					rd_data_o[ST_WSYNC]   <= 1'b0; // [RULE7]
					rd_data_o[ST_LINK_RUN] <= link_run_o;
					rd_data_o[ST_TX_BUSY] <= tx_busy_q;
				end
				OFS_MASK:     rd_data_o[EV_W-1:0] <= mask_q;
				OFS_CLKDIV: begin
					rd_data_o[CDIV_RUN_LSB +: DIV_W]   <= div_run_q;
					rd_data_o[CDIV_START_LSB +: DIV_W] <= div_start_q;
				end
				OFS_NODEADDR: rd_data_o[7:0] <= node_q;
				OFS_RXDATA:   rd_data_o[7:0] <= rxdata_q;
				OFS_RMAPERR:  rd_data_o[7:0] <= rmap_err_q;
				default:      rd_data_o <= '0;
			endcase
		end else begin
			rd_data_o <= '0;
		end
	end

	sequence s_status_read;
		rd_i && (addr_i == OFS_STATUS);
	endsequence

	sequence s_last_start_tick;
		(lnk_q == LNK_START) && ctrl_q[CTRL_LINK_EN] && bit_tick && (scnt_q == START_TICKS - 8'h01);
	endsequence

	sequence s_tx_last_bit;
		tx_busy_q && bit_tick && (tx_cnt_q == 4'h1);
	endsequence

	AST_WSYNC_ZERO: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE7]
		s_status_read |=> (rd_data_o[ST_WSYNC] == 1'b0))
		else $error("write sync error bit read as one");

	AST_LOOP_RESET: assert property (@(posedge ref_clk_i) // [RULE11]
		!nrst_i |=> !ctrl_q[CTRL_LOOP] && !rx_valid)
		else $error("loopback set after reset");

	AST_LOOP_PATH: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE8]
		ctrl_q[CTRL_LOOP] |-> (rx_d_sel == tx_d_o) && (rx_s_sel == tx_s_o))
		else $error("loopback path not taken");

	AST_CLK_TOGGLE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE1]
		bit_tick && (lnk_q != LNK_OFF) |=> (link_bit_clk_o != $past(link_bit_clk_o)))
		else $error("link clock missed a tick");

	AST_TX_ON_TICK: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE1]
		($changed(tx_d_o) || $changed(tx_s_o)) |-> $past(bit_tick) && !($changed(tx_d_o) && $changed(tx_s_o)))
		else $error("transmit pin moved off the link tick");

	AST_START_DONE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE6]
		s_last_start_tick |=> (lnk_q == LNK_RUN) && link_run_o)
		else $error("start-up did not end on the last start tick");

	AST_NO_EARLY_RUN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE6]
		$rose(ctrl_q[CTRL_LINK_EN]) && (lnk_q == LNK_OFF) |=> !link_run_o [*8])
		else $error("link ran before start-up");

	AST_DEST_ERR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE10]
		dest_bad |=> (rmap_err_q == ERR_INV_DEST) && evt_q[ST_RMAP_EV])
		else $error("invalid destination not reported");

	AST_RMAP_OFF: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE5]
		rx_valid && !ctrl_q[CTRL_RMAP_EN] |=> (rmap_err_q == $past(rmap_err_q)))
		else $error("RMAP check ran while disabled");

	AST_IRQ: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		|(evt_q & mask_q) |=> irq_o)
		else $error("interrupt not raised");

	AST_TX_DONE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		s_tx_last_bit |=> !tx_busy_q && evt_q[ST_TX_EV])
		else $error("transmit byte did not finish on its last tick");

	AST_TX_CUT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(lnk_q == LNK_OFF) |=> !tx_busy_q)
		else $error("transmitter stayed busy with the link off");

	AST_RX_ON_TICK: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE1]
		rx_valid |-> $past(bit_tick))
		else $error("receive byte completed off the link tick");

	AST_EV_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		wr_i && (addr_i == OFS_STATUS) && wr_data_i[ST_RX_EV] && !ev_set[ST_RX_EV] |=> !evt_q[ST_RX_EV])
		else $error("write one did not clear the status bit");
endmodule : spwpc_port

// *** spwpc_far_node.sv ***
// far-end link node model: drives the port's receive pins and decodes its transmit pins
`timescale 1ns/100ps
module spwpc_far_node (
	input  wire logic link_bit_clk_i,
	input  wire logic tx_d_i,
	input  wire logic tx_s_i,
	output logic      d_o,
	output logic      s_o
);
	initial begin
		d_o = 1'b0;
		s_o = 1'b0;
	end

	// one bit per link clock period: half the tick rate, inside the receive limit
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge link_bit_clk_i);
			if (b[i] == d_o) s_o <= ~s_o;
			d_o <= b[i];
		end
		@(posedge link_bit_clk_i);
	endtask : send_byte

	// every bit toggles exactly one of the two pins, so each change carries one bit
	task automatic recv_byte(output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(tx_d_i or tx_s_i);
			b[i] = tx_d_i;
		end
	endtask : recv_byte
endmodule : spwpc_far_node

// *** spacewire_port_config_deltas_tb_top.sv ***
// self-checking bench for one link port with a far-end node model
`timescale 1ns/100ps
module spacewire_port_config_deltas_tb_top;
	import spwpc_pkg::*;
	logic              ref_clk_i, nrst_i, wr_i, rd_i, irq_o, rx_d_i, rx_s_i;
	logic              tx_d_o, tx_s_o, link_bit_clk_o, link_run_o;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wr_data_i, rd_data_o, rd_q;
	int                failures, n_checks, cycles;

	// the remote memory target must sit on every port number; the lowest one is exercised
	spwpc_port #(.PORT_ID(0)) spwpc_port_inst (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o), .rx_d_i(rx_d_i),
		.rx_s_i(rx_s_i), .tx_d_o(tx_d_o), .tx_s_o(tx_s_o), .link_bit_clk_o(link_bit_clk_o),
		.link_run_o(link_run_o));
	spwpc_far_node spwpc_far_node_inst (.link_bit_clk_i(link_bit_clk_o), .tx_d_i(tx_d_o), .tx_s_i(tx_s_o),
		.d_o(rx_d_i), .s_o(rx_s_i));

	// link clock is divided on chip, so it never exceeds this clock
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures++;
			finish_test();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 rd_q = rd_data_o;
	endtask : rd

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		rd(a);
		check(name, rd_q, exp);
	endtask : rd_chk

	task automatic wait_st(input int b);
		for (int i = 0; i < 300; i++) begin
			rd(OFS_STATUS);
			if (rd_q[b] === 1'b1) break;
		end
	endtask : wait_st

	task automatic send_rx(input logic [7:0] b);
		spwpc_far_node_inst.send_byte(b);
		wait_st(ST_RX_EV);
		wr(OFS_STATUS, 32'h0000_0001);
	endtask : send_rx

	task automatic start_link(input logic [7:0] st);
		int n;
		int s;
		n = 0;
		s = int'(st);
		wr(OFS_CTRL, 32'h0000_0000);
		wr(OFS_CLKDIV, {16'h0000, st, 8'h01});
		rd_chk(OFS_CLKDIV, {16'h0000, st, 8'h01}, "clkdiv");
		wr(OFS_CTRL, 32'h0000_0001);
		while (link_run_o !== 1'b1 && n < 2000) begin
			@(posedge ref_clk_i);
			#1 n++;
		end
		// first start tick lands one cycle after entry, so only START_TICKS-1 whole periods follow
		check("start_time", 32'(n), 32'((int'(START_TICKS) - 1) * (s + 1) + 2));
	endtask : start_link

	task automatic test_reset;
		rd_chk(OFS_CTRL, CTRL_RST, "ctrl");
		rd_chk(OFS_STATUS, 32'h0, "status");
		rd_chk(OFS_MASK, 32'h0, "mask");
		rd_chk(OFS_CLKDIV, {16'h0000, DIV_START_RST, DIV_RUN_RST}, "clkdiv");
		rd_chk(OFS_NODEADDR, {24'h0, NODEADDR_RST}, "nodeaddr");
		wr(8'h20, 32'hffff_ffff);
		rd_chk(8'h20, 32'h0, "unmapped");
		rd_chk(OFS_CTRL, 32'h0, "ctrl_kept");
		check("irq", {31'h0, irq_o}, 32'h0);
		check("link_run", {31'h0, link_run_o}, 32'h0);
		$display("test_reset done");
	endtask : test_reset

	task automatic test_startup;
		start_link(8'h02);
		start_link(DIV_START_RST);
		wr(OFS_STATUS, 32'hffff_ffff);
		rd(OFS_STATUS);
		check("st_run", {31'h0, rd_q[ST_LINK_RUN]}, 32'h1);
		check("st_wsync", {31'h0, rd_q[ST_WSYNC]}, 32'h0);
		$display("test_startup done");
	endtask : test_startup

	task automatic test_rmap;
		wr(OFS_MASK, 32'h0000_0002);
		wr(OFS_CTRL, 32'h0000_0003);
		spwpc_far_node_inst.send_byte(8'h55);
		wait_st(ST_RMAP_EV);
		check("irq_dest", {31'h0, irq_o}, 32'h1);
		rd_chk(OFS_RMAPERR, {24'h0, ERR_INV_DEST}, "err_code");
		rd_chk(OFS_RXDATA, 32'h55, "rx_byte");
		wr(OFS_STATUS, 32'h0000_0007);
		rd(OFS_STATUS);
		check("st_clear", {29'h0, rd_q[2:0]}, 32'h0);
		check("irq_clear", {31'h0, irq_o}, 32'h0);
		send_rx(PKT_END);
		send_rx(NODEADDR_RST);
		rd_chk(OFS_RMAPERR, {24'h0, ERR_NONE}, "err_match");
		wr(OFS_CTRL, 32'h0000_0001);
		send_rx(PKT_END);
		send_rx(8'h55);
		rd(OFS_STATUS);
		check("rmap_off", {31'h0, rd_q[ST_RMAP_EV]}, 32'h0);
		wr(OFS_MASK, 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0003);
		send_rx(PKT_END);
		send_rx(8'h55);
		rd(OFS_STATUS);
		check("rmap_on", {31'h0, rd_q[ST_RMAP_EV]}, 32'h1);
		check("irq_masked", {31'h0, irq_o}, 32'h0);
		$display("test_rmap done");
	endtask : test_rmap

	task automatic test_loop;
		logic [7:0] rx_b;
		wr(OFS_CTRL, 32'h0040_0001);
		rd_chk(OFS_CTRL, 32'h0040_0001, "ctrl_loop");
		wr(OFS_STATUS, 32'h0000_0007);
		// far end keeps talking: the loop must shut the pins out
		fork
			spwpc_far_node_inst.send_byte(8'h33);
			wr(OFS_TXDATA, 32'h0000_00a5);
		join
		wait_st(ST_TX_EV);
		wait_st(ST_RX_EV);
		rd_chk(OFS_RXDATA, 32'h0000_00a5, "loop_byte");
		wr(OFS_CTRL, 32'h0000_0001);
		wr(OFS_STATUS, 32'h0000_0007);
		// loop cleared: the byte leaves on the pins, a write while busy is refused, nothing echoes
		fork
			spwpc_far_node_inst.recv_byte(rx_b);
			begin
				wr(OFS_TXDATA, 32'h0000_003c);
				wr(OFS_TXDATA, 32'h0000_0081);
			end
		join
		wait_st(ST_TX_EV);
		check("tx_pins", {24'h0, rx_b}, 32'h3c);
		check("no_echo", {31'h0, rd_q[ST_RX_EV]}, 32'h0);
		check("tx_idle", {31'h0, rd_q[ST_TX_BUSY]}, 32'h0);
		nrst_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		rd_chk(OFS_CTRL, CTRL_RST, "ctrl_rerst");
		check("run_rerst", {31'h0, link_run_o}, 32'h0);
		$display("test_loop done");
	endtask : test_loop

	initial begin
		nrst_i = 1'b0;
		addr_i = '0;
		wr_data_i = '0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		failures = 0;
		n_checks = 0;
		repeat (3) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		test_reset();
		test_startup();
		test_rmap();
		test_loop();
		finish_test();
	end
endmodule : spacewire_port_config_deltas_tb_top
